// file: design/gpp_cfg.svh
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// Register offsets on the configuration register port
`define GPP_DIR_OFS       8'hB4
`define GPP_DATA_OFS      8'hB6

// Field layout
`define GPP_PIN_CNT       8
`define GPP_SB_CLK_PIN    4
`define GPP_SB_DATA_PIN   5
`define GPP_SEC_MASK      8'h30

// Reset values
`define GPP_DIR_RST       8'h00
`define GPP_DATA_RST      8'h00
`define GPP_RSVD_VAL      8'h00
`define GPP_OE_N_RST      8'hFF

`endif

// file: design/gpp_pkg.sv
package gpp_pkg;

    // One register access on the configuration port
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  be;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } gpp_req_s;

    // Serial-bus controller drive towards pins 4 and 5
    typedef struct packed {
        logic clk_out;
        logic clk_oe_n;
        logic data_out;
        logic data_oe_n;
    } gpp_sb_drv_s;

    typedef struct packed {
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [7:0]  pin_s3;
        logic [7:0]  level;
        logic [2:0]  plt_sync;
        logic [2:0]  glb_sync;
        logic        plt_lvl;
        logic        glb_lvl;
        logic        fundamental_reset_n_n;
        logic [7:0]  dir;
        logic [7:0]  data;
        logic [15:0] rdata;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe_n;
        logic        sb_clk_in;
        logic        sb_data_in;
    } gpp_state_s;

endpackage

// file: design/gpp_port.sv
`timescale 1ns/100ps
`include "gpp_cfg.svh"

// Overview of operation
// - One direction bit per pin; 0 is input (default), 1 is output.
// - Data reads return the sampled pin level for input-mode pins.
// - Data writes to output-mode pins set the driven level.
// - Data writes to input-mode pins are discarded, nothing changes.
// - Data writes to pins in secondary function are discarded.
// - Only pins 4 and 5 have a secondary role: serial clock, data.
// - Bits 15 to 8 of both registers read zero, ignore writes.
// - After power-up all pins are inputs; data reads show pin levels.
// - Only the fundamental reset clears direction and data bits.
// - Fundamental reset, active low, follows platform or global reset.
// - Direction bits do not affect pins in secondary function.
// - Serial memory present puts pins 4 and 5 in serial-bus role.
module gpp_port (
    input  wire logic                 core_clk,            // 50 MHz clock
    input  wire logic                 sys_rst,             // Sync reset
    input  wire logic                 platform_reset_n,    // Reset pin
    input  wire logic                 global_reset_n,      // Reset pin
    input  wire gpp_pkg::gpp_req_s    reg_req,             // Register access
    output logic [15:0]               reg_rdata,           // Read data
    input  wire logic [7:0]           pin_in,              // Pin levels
    output logic [7:0]                pin_out,             // Pin drive value
    output logic [7:0]                pin_oe_n,            // Low drives pin
    input  wire logic                 serial_memory_present, // From sb ctrl
    input  wire gpp_pkg::gpp_sb_drv_s sb_drv,              // Sb ctrl drive
    output logic                      sb_clk_in,           // Pin 4 level
    output logic                      sb_data_in,          // Pin 5 level
    output logic                      fundamental_reset_n  // Internal reset
);
    import gpp_pkg::*;

    gpp_state_s s_reg;
    gpp_state_s s_next;
    gpp_state_s s_rst;
    logic [7:0] sec;
    logic [7:0] drv_mask;
    logic       dir_wr;
    logic       data_wr;

    assign sec      = serial_memory_present ? `GPP_SEC_MASK : 8'h00;
    assign drv_mask = s_reg.dir & ~sec;
    assign dir_wr   = reg_req.wr && reg_req.be[0]
                      && reg_req.addr == `GPP_DIR_OFS;
    assign data_wr  = reg_req.wr && reg_req.be[0]
                      && reg_req.addr == `GPP_DATA_OFS;

    always_comb begin
        s_next = s_reg;
        // Three-stage sampling of the pins; a level counts once 2 and 3 agree
        s_next.pin_s1 = pin_in;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.pin_s3 = s_reg.pin_s2;
        for (int i = 0; i < `GPP_PIN_CNT; i++) begin
            if (s_reg.pin_s2[i] == s_reg.pin_s3[i]) begin
                s_next.level[i] = s_reg.pin_s3[i];
            end
        end
        s_next.plt_sync = {s_reg.plt_sync[1:0], platform_reset_n};
        s_next.glb_sync = {s_reg.glb_sync[1:0], global_reset_n};
        if (s_reg.plt_sync[1] == s_reg.plt_sync[2]) begin
            s_next.plt_lvl = s_reg.plt_sync[2];
        end
        if (s_reg.glb_sync[1] == s_reg.glb_sync[2]) begin
            s_next.glb_lvl = s_reg.glb_sync[2];
        end
        s_next.fundamental_reset_n_n = s_reg.plt_lvl & s_reg.glb_lvl;

        // Register writes; upper byte has no storage at all
        if (dir_wr) begin
            s_next.dir = reg_req.wdata[7:0];
        end
        for (int i = 0; i < `GPP_PIN_CNT; i++) begin
            if (data_wr && drv_mask[i]) begin
                s_next.data[i] = reg_req.wdata[i];
            end
        end
        if (!s_reg.fundamental_reset_n_n) begin
            s_next.dir  = `GPP_DIR_RST;
            s_next.data = `GPP_DATA_RST;
        end

        // Reads: output bits show the driven value, others the pin level
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `GPP_DIR_OFS:  s_next.rdata = {`GPP_RSVD_VAL, s_reg.dir};
                `GPP_DATA_OFS: s_next.rdata = {`GPP_RSVD_VAL,
                                  (s_reg.data & drv_mask)
                                  | (s_reg.level & ~drv_mask)};
                default:       s_next.rdata = 16'h0000;
            endcase
        end

        // Pin drive, with the serial controller owning pins 4 and 5
        s_next.pin_out  = s_reg.data;
        s_next.pin_oe_n = ~s_reg.dir;
        if (sec[`GPP_SB_CLK_PIN]) begin
            s_next.pin_out[`GPP_SB_CLK_PIN]   = sb_drv.clk_out;
            s_next.pin_oe_n[`GPP_SB_CLK_PIN]  = sb_drv.clk_oe_n;
            s_next.pin_out[`GPP_SB_DATA_PIN]  = sb_drv.data_out;
            s_next.pin_oe_n[`GPP_SB_DATA_PIN] = sb_drv.data_oe_n;
        end
        s_next.sb_clk_in  = s_reg.level[`GPP_SB_CLK_PIN];
        s_next.sb_data_in = s_reg.level[`GPP_SB_DATA_PIN];
    end

    // Core reset starts the reset filters asserted, so the fundamental
    // reset clears the direction and data bits; the core reset itself never does.
    always_comb begin
        s_rst          = '0;
        s_rst.pin_oe_n = `GPP_OE_N_RST;
        s_rst.dir      = s_reg.dir;
        s_rst.data     = s_reg.data;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_reg <= s_rst;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata           = s_reg.rdata;
    assign pin_out             = s_reg.pin_out;
    assign pin_oe_n            = s_reg.pin_oe_n;
    assign sb_clk_in           = s_reg.sb_clk_in;
    assign sb_data_in          = s_reg.sb_data_in;
    assign fundamental_reset_n = s_reg.fundamental_reset_n_n;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence plat_low_seq;
        !platform_reset_n [*4];
    endsequence
    sequence glob_low_seq;
        !global_reset_n [*4];
    endsequence

    // Filter stages restart at core reset, hence four steady samples
    sequence pin_steady_seq;
        $stable(pin_in) [*4];
    endsequence

    // Fundamental reset: registers clear first, pins turn to inputs next
    sequence cleared_seq;
        s_reg.dir == 8'h00 && s_reg.data == 8'h00;
    endsequence
    sequence inputs_seq;
        (pin_oe_n | $past(sec)) == 8'hFF;
    endsequence

    // Register port checks

    chk_dir_write: assert property (
        dir_wr && s_reg.fundamental_reset_n_n |=> s_reg.dir == $past(reg_req.wdata[7:0]))
        else $error("direction write not stored");
    chk_in_read: assert property (
        reg_req.rd && reg_req.addr == `GPP_DATA_OFS |=>
        ((reg_rdata[7:0] ^ $past(s_reg.level)) & ~$past(drv_mask)) == 8'h00)
        else $error("input pin read wrong");
    chk_out_read: assert property (
        reg_req.rd && reg_req.addr == `GPP_DATA_OFS |=>
        ((reg_rdata[7:0] ^ $past(s_reg.data)) & $past(drv_mask)) == 8'h00)
        else $error("output pin read wrong");
    chk_out_drive: assert property (
        data_wr && s_reg.fundamental_reset_n_n && !serial_memory_present |-> ##2
        ((pin_out ^ $past(reg_req.wdata[7:0], 2)) & $past(s_reg.dir, 2))
        == 8'h00)
        else $error("written level not driven");
    chk_in_discard: assert property (
        data_wr && s_reg.fundamental_reset_n_n |=>
        ((s_reg.data ^ $past(s_reg.data)) & ~$past(s_reg.dir))
        == 8'h00)
        else $error("input-mode bit was written");
    chk_sec_discard: assert property (
        data_wr && serial_memory_present && s_reg.fundamental_reset_n_n |=>
        s_reg.data[5:4] == $past(s_reg.data[5:4]))
        else $error("secondary pin bit was written");
    chk_sec_pins: assert property (
        serial_memory_present |=> pin_oe_n[`GPP_SB_CLK_PIN]
        == $past(sb_drv.clk_oe_n) && pin_out[`GPP_SB_DATA_PIN]
        == $past(sb_drv.data_out))
        else $error("serial function lost its pins");
    chk_rsvd_zero: assert property (
        reg_req.rd |=> reg_rdata[15:8] == 8'h00)
        else $error("reserved bits not zero");
    // Pin and reset checks
    chk_fundamental_reset_n_clear: assert property (
        !s_reg.fundamental_reset_n_n |=> cleared_seq ##1 inputs_seq)
        else $error("fundamental reset did not clear");
    chk_plat_reset: assert property (
        plat_low_seq |-> ##[1:3] !fundamental_reset_n)
        else $error("platform reset not followed");
    chk_glob_reset: assert property (
        glob_low_seq |-> ##[1:3] !fundamental_reset_n)
        else $error("global reset not followed");
    chk_pin_filter: assert property (
        pin_steady_seq |=> s_reg.level == $past(pin_in))
        else $error("pin level filter wrong");
    chk_unmapped_rd: assert property (
        reg_req.rd && reg_req.addr != `GPP_DIR_OFS
        && reg_req.addr != `GPP_DATA_OFS |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_dir_oe: assert property (
        s_reg.fundamental_reset_n_n && !serial_memory_present |=>
        pin_oe_n == ~$past(s_reg.dir))
        else $error("output enable does not follow direction");
    chk_pin_drive: assert property (
        s_reg.fundamental_reset_n_n |=>
        ((pin_out ^ $past(s_reg.data)) & ~$past(sec)) == 8'h00)
        else $error("pin drive differs from data");
    chk_sb_level: assert property (
        serial_memory_present |=>
        sb_clk_in == $past(s_reg.level[`GPP_SB_CLK_PIN])
        && sb_data_in == $past(s_reg.level[`GPP_SB_DATA_PIN]))
        else $error("serial inputs not fed from pins");
    // Core reset is excluded here: it clears through the fundamental reset
    chk_no_clear: assert property (
        s_reg.fundamental_reset_n_n && !dir_wr && !data_wr |=>
        $stable(s_reg.dir) && $stable(s_reg.data))
        else $error("registers changed without write or reset");

endmodule

// file: tb/gpp_pins_model.sv
`timescale 1ns/100ps
// Board side: a pin the port drives shows that value, else the board level
module gpp_pins_model (
    input  wire logic [7:0] pin_out,   // Port drive value
    input  wire logic [7:0] pin_oe_n,  // Low drives pin
    input  wire logic [7:0] board_lvl, // Board level on undriven pins
    output logic      [7:0] pin_in     // Resolved pin levels
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe_n[i] ? board_lvl[i] : pin_out[i];
        end
    end
endmodule

// file: tb/gpp_port_tb.sv
`timescale 1ns/100ps
`include "gpp_cfg.svh"
module gpp_port_tb;
    import gpp_pkg::*;
    localparam logic [7:0] dir_a = `GPP_DIR_OFS;
    localparam logic [7:0] dat_a = `GPP_DATA_OFS;
    logic        core_clk, sys_rst, plt_n, glb_n, sm_on, sbc, sbd, fundamental_reset_n_n;
    gpp_req_s    req;
    gpp_sb_drv_s sb;
    logic [15:0] rdata;
    logic [7:0]  pin_out, pin_oe_n, pin_in, board;
    int          err_count, cmp_count;
    gpp_port dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .platform_reset_n(plt_n), .global_reset_n(glb_n), .reg_req(req),
        .reg_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .serial_memory_present(sm_on), .sb_drv(sb),
        .sb_clk_in(sbc), .sb_data_in(sbd), .fundamental_reset_n(fundamental_reset_n_n));
    gpp_pins_model board_m (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .board_lvl(board), .pin_in(pin_in));
    task automatic stop_test;
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        req = '{rd: 1'b0, wr: 1'b1, be: 2'h3, addr: a, wdata: d};
        @(negedge core_clk);
        req.wr = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rd(input string w, input logic [7:0] a,
                      input logic [15:0] e);
        @(negedge core_clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge core_clk);
        req.rd = 1'b0;
        chk(w, e, rdata);
    endtask
    // Writes before the fundamental reset lifts would be lost
    task automatic wait_fundamental_reset_n;
        for (int i = 0; i < 20 && fundamental_reset_n_n !== 1'b1; i++) @(negedge core_clk);
        chk("fundamental_reset_n_n", 16'h0001, {15'h0000, fundamental_reset_n_n});
        repeat (4) @(negedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        err_count++;
        stop_test();
    end
    initial begin
        err_count = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        plt_n = 1'b1;
        glb_n = 1'b1;
        sm_on = 1'b0;
        sb = '{clk_out: 1'b1, clk_oe_n: 1'b0, data_out: 1'b0, data_oe_n: 1'b0};
        req = '0;
        board = 8'hA5;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        wait_fundamental_reset_n();
        chk("oe_n", 16'h00FF, {8'h00, pin_oe_n});
        rd("dir", dir_a, 16'h0000);
        rd("data", dat_a, 16'h00A5);
        wr(dir_a, 16'hFF0F);
        rd("dir", dir_a, 16'h000F);
        wr(dat_a, 16'hFFFF);
        chk("oe_n", 16'h00F0, {8'h00, pin_oe_n});
        chk("out", 16'h000F, {12'h000, pin_out[3:0]});
        rd("data", dat_a, 16'h00AF);
        wr(dat_a, 16'h0000);
        wr(dir_a, 16'h00FF);
        chk("out", 16'h0000, {8'h00, pin_out});
        wr(dat_a, 16'h00FF);
        @(negedge core_clk);
        sm_on = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("out", 16'h00DF, {8'h00, pin_out});
        wr(dat_a, 16'h0000);
        wr(dir_a, 16'h0000);
        chk("oe_n", 16'h00CF, {8'h00, pin_oe_n});
        repeat (4) @(negedge core_clk);
        chk("sb_in", 16'h0001, {14'h0000, sbd, sbc});
        sm_on = 1'b0;
        wr(dir_a, 16'h00FF);
        chk("out", 16'h0030, {8'h00, pin_out});
        rd("unmapped", 8'hB8, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            plt_n = (k != 0);
            glb_n = (k == 0);
            repeat (6) @(negedge core_clk);
            chk("fundamental_reset_n_n", 16'h0000, {15'h0000, fundamental_reset_n_n});
            plt_n = 1'b1;
            glb_n = 1'b1;
            wait_fundamental_reset_n();
            rd("dir", dir_a, 16'h0000);
            chk("oe_n", 16'h00FF, {8'h00, pin_oe_n});
            wr(dir_a, 16'h00FF);
        end
        stop_test();
    end
endmodule
